// ---- rtl/ccsr_pkg.sv ----
// Shared constants and types of the CPU control and status registers.
package ccsr_pkg;
  localparam int PC_W = 24;
  localparam int DATA_W = 32;
  localparam int INSN_TYPES = 65;
  localparam logic [1:0] BLOCK_STATES = 2'h3;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] STK_WORD = 24'h000002;
  localparam logic [23:0] STK_LONG = 24'h000004;
  // Extended control register layout.
  localparam int EXR_T = 7;
  localparam logic [7:0] EXR_RSVD = 8'h78;
  localparam logic [7:0] EXR_MASK = 8'h07;
  localparam logic [7:0] EXR_RST = 8'h7f;
  // Condition-code register layout.
  localparam int CCR_I = 7;
  localparam int CCR_UI = 6;
  localparam int CCR_H = 5;
  localparam int CCR_U = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_RST = 8'h80;
  // Operands are left-aligned so one carry tap serves every size.
  localparam int H_TAP = 28;
  localparam logic [5:0] SH_BYTE = 6'h18;
  localparam logic [5:0] SH_WORD = 6'h10;
  localparam logic [5:0] SH_LONG = 6'h00;
  localparam logic [7:0] BCD_HI_LIM = 8'h99;
  localparam logic [3:0] BCD_LO_LIM = 4'h9;
  localparam logic [7:0] BCD_HI_ADJ = 8'h60;
  localparam logic [7:0] BCD_LO_ADJ = 8'h06;
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} ccsr_size_e;
  typedef enum logic [3:0] {
    ALU_NONE = 4'h0, ALU_ADD = 4'h1, ALU_ADDX = 4'h2, ALU_SUB = 4'h3,
    ALU_SUBX = 4'h4, ALU_CMP = 4'h5, ALU_NEG = 4'h6, ALU_LOGIC = 4'h7,
    ALU_SHIFT = 4'h8, ALU_DAA = 4'h9, ALU_DAS = 4'ha
  } ccsr_alu_e;
  typedef enum logic [2:0] {
    CTL_NONE = 3'h0, CTL_LOAD = 3'h1, CTL_AND = 3'h2, CTL_OR = 3'h3,
    CTL_XOR = 3'h4, CTL_STORE = 3'h5
  } ccsr_ctl_e;
  typedef enum logic [2:0] {
    BIT_NONE = 3'h0, BIT_LOAD = 3'h1, BIT_AND = 3'h2, BIT_OR = 3'h3,
    BIT_XOR = 3'h4, BIT_TEST = 3'h5, BIT_STORE = 3'h6
  } ccsr_bit_e;
  typedef enum logic [2:0] {
    CLS_XFER = 3'h0, CLS_ARITH = 3'h1, CLS_LOGIC = 3'h2, CLS_SHIFT = 3'h3,
    CLS_BIT = 3'h4, CLS_BRANCH = 3'h5, CLS_SYS = 3'h6, CLS_BLOCK = 3'h7
  } ccsr_class_e;
  typedef enum logic [1:0] {STK_NONE = 2'h0, STK_PUSH = 2'h1, STK_POP = 2'h2} ccsr_stk_e;
  typedef enum logic [3:0] {
    CC_T = 4'h0, CC_F = 4'h1, CC_HI = 4'h2, CC_LS = 4'h3, CC_CC = 4'h4, CC_CS = 4'h5,
    CC_NE = 4'h6, CC_EQ = 4'h7, CC_VC = 4'h8, CC_VS = 4'h9, CC_PL = 4'ha, CC_MI = 4'hb,
    CC_GE = 4'hc, CC_LT = 4'hd, CC_GT = 4'he, CC_LE = 4'hf
  } ccsr_cond_e;
endpackage

// ---- rtl/ccsr_alu_if.sv ----
// Link between the register core and its flag computation unit.
`timescale 1ns/1ps
interface ccsr_alu_if;
  ccsr_pkg::ccsr_alu_e op;
  ccsr_pkg::ccsr_size_e size;
  logic [31:0] a;
  logic [31:0] b;
  logic cin;
  logic [31:0] res;
  logic [4:0] flags;
  logic [4:0] upd;
  modport unit(input op, size, a, b, cin, output res, flags, upd);
  modport core(output op, size, a, b, cin, input res, flags, upd);
endinterface

// ---- rtl/ccsr_flag_unit.sv ----
// Arithmetic flag computation; flags and upd are ordered {h, n, z, v, c}.
`timescale 1ns/1ps
module ccsr_flag_unit (
  ccsr_alu_if.unit bus
);
  function automatic logic [5:0] align(input ccsr_pkg::ccsr_size_e s);
    unique case (s)
      ccsr_pkg::SZ_BYTE: align = ccsr_pkg::SH_BYTE;
      ccsr_pkg::SZ_WORD: align = ccsr_pkg::SH_WORD;
      default: align = ccsr_pkg::SH_LONG;
    endcase
  endfunction

  always_comb begin
    logic [5:0] sh;
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] ci;
    logic [32:0] s;
    logic h;
    logic v;
    sh = align(bus.size);
    x = bus.a << sh;
    y = bus.b << sh;
    ci = {31'h0, bus.cin} << sh;
    s = {1'b0, x};
    h = 1'b0;
    v = 1'b0;
    bus.upd = 5'h1f;
    unique case (bus.op)
      ccsr_pkg::ALU_ADD, ccsr_pkg::ALU_ADDX: begin
        s = {1'b0, x} + {1'b0, y} + ((bus.op == ccsr_pkg::ALU_ADDX) ? {1'b0, ci} : 33'h0);
        v = (x[31] == y[31]) && (s[31] != x[31]);
      end
      ccsr_pkg::ALU_SUB, ccsr_pkg::ALU_SUBX, ccsr_pkg::ALU_CMP: begin
        s = {1'b0, x} - {1'b0, y} - ((bus.op == ccsr_pkg::ALU_SUBX) ? {1'b0, ci} : 33'h0);
        v = (x[31] != y[31]) && (s[31] != x[31]);
      end
      ccsr_pkg::ALU_NEG: begin
        y = x;
        x = 32'h0;
        s = 33'h0 - {1'b0, y};
        v = y[31] && s[31];
      end
      ccsr_pkg::ALU_LOGIC: bus.upd = 5'h0e;
      ccsr_pkg::ALU_SHIFT: begin
        s[32] = bus.cin;
        bus.upd = 5'h0f;
      end
      ccsr_pkg::ALU_NONE, ccsr_pkg::ALU_DAA, ccsr_pkg::ALU_DAS: bus.upd = 5'h00;
      default: bus.upd = 5'h00;
    endcase
    // Carry or borrow out of bit 3, 11 or 27 lands on the same tap.
    h = s[ccsr_pkg::H_TAP] ^ x[ccsr_pkg::H_TAP] ^ y[ccsr_pkg::H_TAP];
    bus.res = s[31:0] >> sh;
    // Sign, zero, overflow and carry.
    bus.flags = {h, s[31], (s[31:0] == 32'h0), v, s[32]};
  end
endmodule

// ---- rtl/ccsr_core.sv ----
// Program counter, extended control and condition-code registers of the CPU.
// Overview of operation
// - Keep a 24-bit counter; instruction fetch treats bit zero as 0.
// - Trace bit set raises a trace exception after every executed instruction.
// - Extended control bits 6 to 3 always read as 1.
// - Extended control bits 2 to 0 hold the interrupt mask level 0 to 7.
// - Control load, and, or, xor block all interrupts three states; store does not.
// - Interrupt mask bit masks all but non-maskable; set at exception start.
// - Condition-code bits 6 and 4 are plain software user bits.
// - Half-carry from bit 3, 11 or 27 for add, subtract, compare, negate.
// - Negative flag takes the sign bit of the result.
// - Zero flag set for zero result, cleared otherwise.
// - Overflow flag set on arithmetic overflow, cleared otherwise.
// - Carry holds carry, borrow or shifted-out bit; bit accumulator too.
// - Branch conditions use N, Z, V, C; some instructions keep flags.
// - Reset loads counter from vector, clears trace, sets both masks.
// - Odd word or longword accesses drop address bit zero, no error.
// - Bit operations pick bit 0 to 7 of a byte; BCD is two digits.
// - Push and pop are pre-decrement and post-increment stack moves.
// - The 65 instruction types arrive already sorted into eight classes.
`timescale 1ns/1ps
module ccsr_core (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [23:0] reset_vector_in,
  // Instruction completion and program counter
  input wire logic step_in,
  input wire ccsr_pkg::ccsr_class_e step_class_in,
  input wire logic pc_step_in,
  input wire logic pc_load_in,
  input wire logic [23:0] pc_value_in,
  input wire logic exc_start_in,
  // Arithmetic and shift flag inputs
  input wire ccsr_pkg::ccsr_alu_e alu_op_in,
  input wire ccsr_pkg::ccsr_size_e alu_size_in,
  input wire logic [31:0] alu_a_in,
  input wire logic [31:0] alu_b_in,
  input wire logic shift_out_in,
  // Bit manipulation
  input wire ccsr_pkg::ccsr_bit_e bit_op_in,
  input wire logic bit_invert_in,
  input wire logic [2:0] bit_sel_in,
  input wire logic [7:0] bit_byte_in,
  // Control-register instructions
  input wire ccsr_pkg::ccsr_ctl_e ctl_op_in,
  input wire logic ctl_exr_in,
  input wire logic [7:0] ctl_data_in,
  // Interrupt requests
  input wire logic nmi_in,
  input wire logic irq_in,
  input wire logic [2:0] irq_level_in,
  // Branch condition and memory addressing
  input wire ccsr_pkg::ccsr_cond_e cond_in,
  input wire logic [23:0] acc_addr_in,
  input wire logic acc_wide_in,
  input wire ccsr_pkg::ccsr_stk_e stack_op_in,
  input wire logic stack_long_in,
  input wire logic [23:0] sp_in,
  // Register views
  output logic [23:0] pc_out,
  output logic [23:0] fetch_addr_out,
  output logic [7:0] exr_out,
  output logic [7:0] ccr_out,
  output logic [7:0] ctl_read_out,
  output logic [31:0] result_out,
  // Events and addressing results
  output logic trace_exc_out,
  output logic nmi_accept_out,
  output logic irq_accept_out,
  output logic cond_true_out,
  output logic [23:0] acc_addr_out,
  output logic [23:0] stack_addr_out,
  output logic [23:0] sp_next_out
);
  typedef struct packed {
    logic [23:0] pc;
    logic [23:0] fetch;
    logic [7:0] extended_control;
    logic [7:0] condition_code;
    logic [7:0] ctl_read;
    logic [31:0] result;
    logic [1:0] blk;
    logic trace;
    logic nmi_acc;
    logic irq_acc;
    logic cond;
    logic [23:0] acc;
    logic [23:0] stk;
    logic [23:0] sp;
  } ccsr_state_s;

  ccsr_state_s st_q;
  ccsr_state_s st_d;
  ccsr_alu_if alu_bus ();

  ccsr_flag_unit u_flag (
    .bus(alu_bus.unit)
  );

  assign alu_bus.op = alu_op_in;
  assign alu_bus.size = alu_size_in;
  assign alu_bus.a = alu_a_in;
  assign alu_bus.b = alu_b_in;
  assign alu_bus.cin = (alu_op_in == ccsr_pkg::ALU_SHIFT) ? shift_out_in : st_q.condition_code[ccsr_pkg::CCR_C];

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Word and longword accesses never fault; odd ones start one byte lower.
  function automatic logic [23:0] even(input logic [23:0] addr);
    even = {addr[23:1], 1'b0};
  endfunction

  function automatic logic branch_taken(input ccsr_pkg::ccsr_cond_e cc, input logic [7:0] f);
    logic n;
    logic z;
    logic v;
    logic c;
    n = f[ccsr_pkg::CCR_N];
    z = f[ccsr_pkg::CCR_Z];
    v = f[ccsr_pkg::CCR_V];
    c = f[ccsr_pkg::CCR_C];
    unique case (cc)
      ccsr_pkg::CC_T: branch_taken = 1'b1;
      ccsr_pkg::CC_F: branch_taken = 1'b0;
      ccsr_pkg::CC_HI: branch_taken = !(c | z);
      ccsr_pkg::CC_LS: branch_taken = c | z;
      ccsr_pkg::CC_CC: branch_taken = !c;
      ccsr_pkg::CC_CS: branch_taken = c;
      ccsr_pkg::CC_NE: branch_taken = !z;
      ccsr_pkg::CC_EQ: branch_taken = z;
      ccsr_pkg::CC_VC: branch_taken = !v;
      ccsr_pkg::CC_VS: branch_taken = v;
      ccsr_pkg::CC_PL: branch_taken = !n;
      ccsr_pkg::CC_MI: branch_taken = n;
      ccsr_pkg::CC_GE: branch_taken = !(n ^ v);
      ccsr_pkg::CC_LT: branch_taken = n ^ v;
      ccsr_pkg::CC_GT: branch_taken = !(z | (n ^ v));
      ccsr_pkg::CC_LE: branch_taken = z | (n ^ v);
    endcase
  endfunction

  // Returns {carry, adjusted byte}; the byte holds two BCD digits.
  function automatic logic [8:0] bcd_adjust(input logic [7:0] a, input logic c, input logic h,
                                            input logic sub);
    logic [7:0] adj;
    logic co;
    adj = 8'h00;
    co = c;
    if (sub) begin
      if (c) begin
        adj = adj | ccsr_pkg::BCD_HI_ADJ;
      end
      if (h) begin
        adj = adj | ccsr_pkg::BCD_LO_ADJ;
      end
      bcd_adjust = {co, a - adj};
    end else begin
      if (c || (a > ccsr_pkg::BCD_HI_LIM)) begin
        adj = adj | ccsr_pkg::BCD_HI_ADJ;
        co = 1'b1;
      end
      if (h || (a[3:0] > ccsr_pkg::BCD_LO_LIM)) begin
        adj = adj | ccsr_pkg::BCD_LO_ADJ;
      end
      bcd_adjust = {co, a + adj};
    end
  endfunction

  // Reserved positions are forced on every write path.
  function automatic logic [7:0] exr_fix(input logic [7:0] v);
    exr_fix = v | ccsr_pkg::EXR_RSVD;
  endfunction

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] f;
    logic [8:0] bcd;
    logic bit_v;
    logic [7:0] tgt;
    logic [7:0] nv;
    logic [23:0] stk_sz;
    logic blocked;
    st_d = st_q;
    f = st_q.condition_code;
    bcd = 9'h000;
    tgt = 8'h00;
    nv = 8'h00;
    st_d.trace = 1'b0;
    st_d.nmi_acc = 1'b0;
    st_d.irq_acc = 1'b0;
    blocked = (st_q.blk != 2'h0);
    bit_v = 1'b0;
    stk_sz = ccsr_pkg::STK_WORD;

    // Program counter.
    if (pc_load_in) begin
      st_d.pc = pc_value_in;
    end else if (pc_step_in) begin
      st_d.pc = st_q.pc + ccsr_pkg::PC_STEP;
    end

    // Trace exception after each executed instruction.
    st_d.trace = step_in && st_q.extended_control[ccsr_pkg::EXR_T];

    // Flag updates; transfer, branch, system and block classes keep them.
    if (step_in && ((step_class_in == ccsr_pkg::CLS_ARITH) || (step_class_in == ccsr_pkg::CLS_LOGIC) ||
        (step_class_in == ccsr_pkg::CLS_SHIFT))) begin
      if (alu_bus.upd[4]) f[ccsr_pkg::CCR_H] = alu_bus.flags[4];
      if (alu_bus.upd[3]) f[ccsr_pkg::CCR_N] = alu_bus.flags[3];
      if (alu_bus.upd[2]) f[ccsr_pkg::CCR_Z] = alu_bus.flags[2];
      if (alu_bus.upd[1]) f[ccsr_pkg::CCR_V] = alu_bus.flags[1];
      if (alu_bus.upd[0]) f[ccsr_pkg::CCR_C] = alu_bus.flags[0];
      if (alu_bus.upd != 5'h00) begin
        st_d.result = alu_bus.res;
      end
      if ((alu_op_in == ccsr_pkg::ALU_DAA) || (alu_op_in == ccsr_pkg::ALU_DAS)) begin
        bcd = bcd_adjust(alu_a_in[7:0], st_q.condition_code[ccsr_pkg::CCR_C], st_q.condition_code[ccsr_pkg::CCR_H],
                         alu_op_in == ccsr_pkg::ALU_DAS);
        f[ccsr_pkg::CCR_C] = bcd[8];
        f[ccsr_pkg::CCR_N] = bcd[7];
        f[ccsr_pkg::CCR_Z] = (bcd[7:0] == 8'h00);
        st_d.result = {24'h000000, bcd[7:0]};
      end
    end

    // Carry acts as the one-bit accumulator for bit operations.
    bit_v = bit_byte_in[bit_sel_in] ^ bit_invert_in;
    if (step_in && (step_class_in == ccsr_pkg::CLS_BIT)) begin
      unique case (bit_op_in)
        ccsr_pkg::BIT_NONE: ;
        ccsr_pkg::BIT_LOAD: f[ccsr_pkg::CCR_C] = bit_v;
        ccsr_pkg::BIT_AND: f[ccsr_pkg::CCR_C] = f[ccsr_pkg::CCR_C] & bit_v;
        ccsr_pkg::BIT_OR: f[ccsr_pkg::CCR_C] = f[ccsr_pkg::CCR_C] | bit_v;
        ccsr_pkg::BIT_XOR: f[ccsr_pkg::CCR_C] = f[ccsr_pkg::CCR_C] ^ bit_v;
        ccsr_pkg::BIT_TEST: f[ccsr_pkg::CCR_Z] = !bit_byte_in[bit_sel_in];
        ccsr_pkg::BIT_STORE: begin
          nv = bit_byte_in;
          nv[bit_sel_in] = f[ccsr_pkg::CCR_C] ^ bit_invert_in;
          st_d.result = {24'h000000, nv};
        end
        default: ;
      endcase
    end

    // Control-register instructions; user bits are ordinary storage.
    tgt = ctl_exr_in ? st_q.extended_control : f;
    unique case (ctl_op_in)
      ccsr_pkg::CTL_NONE: nv = tgt;
      ccsr_pkg::CTL_LOAD: nv = ctl_data_in;
      ccsr_pkg::CTL_AND: nv = tgt & ctl_data_in;
      ccsr_pkg::CTL_OR: nv = tgt | ctl_data_in;
      ccsr_pkg::CTL_XOR: nv = tgt ^ ctl_data_in;
      ccsr_pkg::CTL_STORE: begin
        nv = tgt;
        st_d.ctl_read = tgt;
      end
      default: nv = tgt;
    endcase
    if (ctl_exr_in) begin
      st_d.extended_control = exr_fix(nv);
    end else begin
      f = nv;
    end

    // Blocking window counts down one state per clock.
    if ((ctl_op_in == ccsr_pkg::CTL_LOAD) || (ctl_op_in == ccsr_pkg::CTL_AND) ||
        (ctl_op_in == ccsr_pkg::CTL_OR) || (ctl_op_in == ccsr_pkg::CTL_XOR)) begin
      st_d.blk = ccsr_pkg::BLOCK_STATES;
    end else if (blocked) begin
      st_d.blk = st_q.blk - 2'h1;
    end

    // Non-maskable ignores the mask bit and level but not the window.
    st_d.nmi_acc = nmi_in && !blocked;
    st_d.irq_acc = irq_in && !nmi_in && !blocked && !st_q.condition_code[ccsr_pkg::CCR_I] &&
                   (irq_level_in > st_q.extended_control[2:0]);

    // Exception start sets the mask bit, beating any flag write this cycle.
    if (exc_start_in || st_d.nmi_acc || st_d.irq_acc) begin
      f[ccsr_pkg::CCR_I] = 1'b1;
    end
    st_d.condition_code = f;

    // Branch condition and access addressing.
    st_d.cond = branch_taken(cond_in, st_q.condition_code);
    st_d.acc = acc_wide_in ? even(acc_addr_in) : acc_addr_in;
    stk_sz = stack_long_in ? ccsr_pkg::STK_LONG : ccsr_pkg::STK_WORD;
    unique case (stack_op_in)
      ccsr_pkg::STK_PUSH: begin
        st_d.stk = even(sp_in - stk_sz);
        st_d.sp = sp_in - stk_sz;
      end
      ccsr_pkg::STK_POP: begin
        st_d.stk = even(sp_in);
        st_d.sp = sp_in + stk_sz;
      end
      ccsr_pkg::STK_NONE: begin
        st_d.stk = even(sp_in);
        st_d.sp = sp_in;
      end
      default: begin
        st_d.stk = even(sp_in);
        st_d.sp = sp_in;
      end
    endcase

    st_d.fetch = even(st_d.pc);

    // Reset exception handling: vector to counter, trace off, masks set.
    if (rst_in) begin
      st_d = '0;
      st_d.pc = reset_vector_in;
      st_d.fetch = even(reset_vector_in);
      st_d.extended_control = ccsr_pkg::EXR_RST;
      st_d.condition_code = ccsr_pkg::CCR_RST;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    st_q <= st_d;
  end

  assign pc_out = st_q.pc;
  assign fetch_addr_out = st_q.fetch;
  assign exr_out = st_q.extended_control;
  assign ccr_out = st_q.condition_code;
  assign ctl_read_out = st_q.ctl_read;
  assign result_out = st_q.result;
  assign trace_exc_out = st_q.trace;
  assign nmi_accept_out = st_q.nmi_acc;
  assign irq_accept_out = st_q.irq_acc;
  assign cond_true_out = st_q.cond;
  assign acc_addr_out = st_q.acc;
  assign stack_addr_out = st_q.stk;
  assign sp_next_out = st_q.sp;
endmodule

// ---- test/ccsr_core_chk.sv ----
// Concurrent checks on the ports of the control and status register core.
`timescale 1ns/1ps
module ccsr_core_chk (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [23:0] reset_vector_in,
  // Requests
  input wire logic step_in,
  input wire logic pc_step_in,
  input wire logic pc_load_in,
  input wire logic [23:0] pc_value_in,
  input wire logic exc_start_in,
  input wire ccsr_pkg::ccsr_ctl_e ctl_op_in,
  input wire logic nmi_in,
  input wire logic irq_in,
  input wire logic [2:0] irq_level_in,
  input wire logic [23:0] acc_addr_in,
  input wire logic acc_wide_in,
  // Observed outputs
  input wire logic [23:0] pc_out,
  input wire logic [23:0] fetch_addr_out,
  input wire logic [7:0] exr_out,
  input wire logic [7:0] ccr_out,
  input wire logic trace_exc_out,
  input wire logic nmi_accept_out,
  input wire logic irq_accept_out,
  input wire logic [23:0] acc_addr_out
);
  // ----------------------------------------
  // Shadow of the interrupt blocking window
  // ----------------------------------------
  logic ctl_blocks;
  logic [1:0] blk_q;
  logic [1:0] blk_d;
  assign ctl_blocks = ctl_op_in inside {ccsr_pkg::CTL_LOAD, ccsr_pkg::CTL_AND, ccsr_pkg::CTL_OR, ccsr_pkg::CTL_XOR};
  always_comb begin
    blk_d = 2'h0;
    if (!rst_in && ctl_blocks) begin
      blk_d = 2'h3;
    end else if (!rst_in && blk_q != 2'h0) begin
      blk_d = blk_q - 2'h1;
    end
  end
  always_ff @(posedge ref_clk_in) begin
    blk_q <= blk_d;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  a_fetch_even: assert property (fetch_addr_out == {pc_out[23:1], 1'b0})
    else $error("Fetch address is not the even counter value.");
  a_pc_load: assert property (pc_load_in |=> pc_out == $past(pc_value_in))
    else $error("Counter load lost.");
  a_pc_step: assert property (pc_step_in && !pc_load_in |=> pc_out == $past(pc_out) + 24'h000002)
    else $error("Counter step is not two.");
  a_trace_on: assert property (step_in && exr_out[7] |=> trace_exc_out)
    else $error("Trace exception missing.");
  a_trace_off: assert property (!step_in || !exr_out[7] |=> !trace_exc_out)
    else $error("Unexpected trace exception.");
  a_exr_rsvd_ones: assert property ((exr_out & 8'h78) == 8'h78)
    else $error("Reserved extended control bits not one.");
  a_irq_level_ok: assert property (irq_in && !nmi_in && !ccr_out[7] && blk_q == 2'h0 && irq_level_in > exr_out[2:0]
    |=> irq_accept_out)
    else $error("Interrupt above mask level refused.");
  a_irq_level_low: assert property (irq_in && !nmi_in && irq_level_in <= exr_out[2:0] |=> !irq_accept_out)
    else $error("Interrupt at or below mask level taken.");
  a_blk_window: assert property (ctl_blocks |-> ##2 (!nmi_accept_out && !irq_accept_out) [*3])
    else $error("Interrupt taken inside blocking window.");
  a_nmi_take: assert property (nmi_in && blk_q == 2'h0 |=> nmi_accept_out && ccr_out[7])
    else $error("Non-maskable request not taken.");
  a_irq_masked: assert property (irq_in && ccr_out[7] && !nmi_in |=> !irq_accept_out)
    else $error("Masked interrupt taken.");
  a_exc_sets_mask: assert property (exc_start_in |=> ccr_out[7])
    else $error("Exception start left mask clear.");
  a_reset_load: assert property (disable iff (1'b0) rst_in |=> pc_out == $past(reset_vector_in)
    && exr_out == 8'h7f && ccr_out[7])
    else $error("Reset values wrong.");
  a_wide_align: assert property (acc_wide_in |=> acc_addr_out == ($past(acc_addr_in) & 24'hfffffe))
    else $error("Wide access address not even.");
  c_nmi: cover property (nmi_accept_out);
  c_irq: cover property (irq_accept_out);
  c_trace: cover property (trace_exc_out);
endmodule
bind ccsr_core ccsr_core_chk i_chk (.ref_clk_in, .rst_in, .reset_vector_in, .step_in, .pc_step_in, .pc_load_in,
  .pc_value_in, .exc_start_in, .ctl_op_in, .nmi_in, .irq_in, .irq_level_in, .acc_addr_in, .acc_wide_in, .pc_out,
  .fetch_addr_out, .exr_out, .ccr_out, .trace_exc_out, .nmi_accept_out, .irq_accept_out, .acc_addr_out);

// ---- test/test_cpu_control_status_registers.sv ----
// Self-checking testbench of the control and status register core.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_cpu_control_status_registers;
  typedef struct {ccsr_pkg::ccsr_alu_e op; ccsr_pkg::ccsr_size_e sz; logic [31:0] a; logic [31:0] b;
    logic sh; logic [31:0] res; logic [7:0] condition_code;} ccsr_row_s;
  logic ref_clk_in, rst_in, step_in, pc_step_in, pc_load_in, exc_start_in, shift_out_in, bit_invert_in;
  logic ctl_exr_in, nmi_in, irq_in, acc_wide_in, stack_long_in;
  logic [2:0] bit_sel_in, irq_level_in;
  logic [7:0] bit_byte_in, ctl_data_in;
  logic [23:0] reset_vector_in, pc_value_in, acc_addr_in, sp_in;
  logic [31:0] alu_a_in, alu_b_in;
  ccsr_pkg::ccsr_class_e step_class_in;
  ccsr_pkg::ccsr_alu_e alu_op_in;
  ccsr_pkg::ccsr_size_e alu_size_in;
  ccsr_pkg::ccsr_bit_e bit_op_in;
  ccsr_pkg::ccsr_ctl_e ctl_op_in;
  ccsr_pkg::ccsr_cond_e cond_in;
  ccsr_pkg::ccsr_stk_e stack_op_in;
  logic [23:0] pc_out, fetch_addr_out, acc_addr_out, stack_addr_out, sp_next_out;
  logic [7:0] exr_out, ccr_out, ctl_read_out;
  logic [31:0] result_out;
  logic trace_exc_out, nmi_accept_out, irq_accept_out, cond_true_out;
  int miscompares = 0;
  int n_compared = 0;
  // Flags of each row follow from the rows above it, so the order matters.
  ccsr_row_s rows [11] = '{
    '{ccsr_pkg::ALU_ADD, ccsr_pkg::SZ_BYTE, 32'h0f, 32'h01, 1'b0, 32'h10, 8'ha0},
    '{ccsr_pkg::ALU_ADD, ccsr_pkg::SZ_BYTE, 32'h80, 32'h80, 1'b0, 32'h00, 8'h87},
    '{ccsr_pkg::ALU_ADDX, ccsr_pkg::SZ_BYTE, 32'h01, 32'h01, 1'b0, 32'h03, 8'h80},
    '{ccsr_pkg::ALU_SUB, ccsr_pkg::SZ_BYTE, 32'h10, 32'h01, 1'b0, 32'h0f, 8'ha0},
    '{ccsr_pkg::ALU_CMP, ccsr_pkg::SZ_WORD, 32'h0, 32'h01, 1'b0, 32'h0, 8'ha9},
    '{ccsr_pkg::ALU_NEG, ccsr_pkg::SZ_LONG, 32'h01, 32'h01, 1'b0, 32'hffffffff, 8'ha9},
    '{ccsr_pkg::ALU_ADD, ccsr_pkg::SZ_WORD, 32'h7fff, 32'h01, 1'b0, 32'h8000, 8'haa},
    '{ccsr_pkg::ALU_SUBX, ccsr_pkg::SZ_BYTE, 32'h05, 32'h02, 1'b0, 32'h03, 8'h80},
    '{ccsr_pkg::ALU_LOGIC, ccsr_pkg::SZ_BYTE, 32'h80, 32'h0, 1'b0, 32'h80, 8'h88},
    '{ccsr_pkg::ALU_SHIFT, ccsr_pkg::SZ_BYTE, 32'h00, 32'h0, 1'b1, 32'h00, 8'h85},
    '{ccsr_pkg::ALU_DAA, ccsr_pkg::SZ_BYTE, 32'h12, 32'h0, 1'b0, 32'h72, 8'h81}};
  ccsr_pkg::ccsr_ctl_e ops [5] = '{ccsr_pkg::CTL_LOAD, ccsr_pkg::CTL_AND, ccsr_pkg::CTL_OR, ccsr_pkg::CTL_XOR,
    ccsr_pkg::CTL_STORE};
  logic [7:0] dat [5] = '{8'h05, 8'hfe, 8'h80, 8'h80, 8'h00};
  logic [7:0] exr_exp [5] = '{8'h7d, 8'h7c, 8'hfc, 8'h7c, 8'h7c};
  ccsr_core i_dut (.*);
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic tick(int n = 1);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic idle;
    step_in = 1'b0;
    pc_step_in = 1'b0;
    pc_load_in = 1'b0;
    exc_start_in = 1'b0;
    ctl_op_in = ccsr_pkg::CTL_NONE;
    bit_op_in = ccsr_pkg::BIT_NONE;
    alu_op_in = ccsr_pkg::ALU_NONE;
  endtask
  function automatic logic [31:0] msk(ccsr_pkg::ccsr_size_e s);
    return (s == ccsr_pkg::SZ_BYTE) ? 32'hff : (s == ccsr_pkg::SZ_WORD) ? 32'hffff : 32'hffffffff;
  endfunction
  task automatic print_verdict;
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Far beyond the roughly seventy cycles the sequence needs.
  initial begin
    #20000;
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    idle();
    rst_in = 1'b1;
    reset_vector_in = 24'h123457;
    {pc_value_in, acc_addr_in, sp_in, alu_a_in, alu_b_in} = '0;
    {shift_out_in, bit_invert_in, bit_sel_in, bit_byte_in, ctl_exr_in, ctl_data_in} = '0;
    {nmi_in, irq_in, irq_level_in, acc_wide_in, stack_long_in} = '0;
    step_class_in = ccsr_pkg::CLS_BRANCH;
    alu_size_in = ccsr_pkg::SZ_BYTE;
    cond_in = ccsr_pkg::CC_T;
    stack_op_in = ccsr_pkg::STK_NONE;
    tick(4);
    rst_in = 1'b0;
    `CHK(pc_out, 24'h123457)
    `CHK(fetch_addr_out, 24'h123456)
    `CHK(exr_out, 8'h7f)
    `CHK(ccr_out, 8'h80)
    foreach (rows[i]) begin
      step_in = 1'b1;
      step_class_in = (rows[i].op == ccsr_pkg::ALU_LOGIC) ? ccsr_pkg::CLS_LOGIC :
        (rows[i].op == ccsr_pkg::ALU_SHIFT) ? ccsr_pkg::CLS_SHIFT : ccsr_pkg::CLS_ARITH;
      alu_op_in = rows[i].op;
      alu_size_in = rows[i].sz;
      {alu_a_in, alu_b_in, shift_out_in} = {rows[i].a, rows[i].b, rows[i].sh};
      tick();
      `CHK(ccr_out, rows[i].condition_code)
      if (rows[i].op != ccsr_pkg::ALU_CMP) `CHK(result_out & msk(rows[i].sz), rows[i].res)
    end
    idle();
    step_class_in = ccsr_pkg::CLS_BRANCH;
    $display("Test flags finished");
    for (int k = 0; k < 5; k++) begin
      ctl_op_in = ops[k];
      ctl_exr_in = 1'b1;
      ctl_data_in = dat[k];
      tick();
      idle();
      step_in = 1'b1;
      nmi_in = 1'b1;
      `CHK(exr_out, exr_exp[k])
      for (int j = 1; j <= 4; j++) begin
        tick();
        `CHK(nmi_accept_out, logic'(j == 4 || k == 4))
        `CHK(trace_exc_out, exr_exp[k][7])
      end
      nmi_in = 1'b0;
      step_in = 1'b0;
    end
    `CHK(ctl_read_out, 8'h7c)
    $display("Test blocking finished");
    ctl_op_in = ccsr_pkg::CTL_LOAD;
    ctl_exr_in = 1'b0;
    ctl_data_in = 8'h50;
    irq_in = 1'b1;
    irq_level_in = 3'h4;
    tick();
    idle();
    `CHK(ccr_out, 8'h50)
    tick(4);
    `CHK(irq_accept_out, 1'b0)
    irq_level_in = 3'h5;
    tick();
    `CHK(irq_accept_out, 1'b1)
    `CHK(ccr_out, 8'hd0)
    tick();
    `CHK(irq_accept_out, 1'b0)
    irq_in = 1'b0;
    ctl_op_in = ccsr_pkg::CTL_LOAD;
    exc_start_in = 1'b1;
    tick();
    idle();
    `CHK(ccr_out, 8'hd0)
    ctl_op_in = ccsr_pkg::CTL_STORE;
    tick();
    idle();
    `CHK(ctl_read_out, 8'hd0)
    $display("Test interrupts finished");
    for (int i = 0; i < 16; i++) begin
      cond_in = ccsr_pkg::ccsr_cond_e'(i);
      tick();
      `CHK(cond_true_out, !i[0])
    end
    step_in = 1'b1;
    step_class_in = ccsr_pkg::CLS_BIT;
    bit_op_in = ccsr_pkg::BIT_LOAD;
    bit_sel_in = 3'h5;
    bit_byte_in = 8'h20;
    tick();
    `CHK(ccr_out, 8'hd1)
    bit_op_in = ccsr_pkg::BIT_STORE;
    bit_sel_in = 3'h2;
    bit_byte_in = 8'h00;
    tick();
    idle();
    `CHK(result_out[7:0], 8'h04)
    $display("Test branch and bit finished");
    {acc_wide_in, acc_addr_in, sp_in, stack_long_in} = {1'b1, 24'h000101, 24'h001000, 1'b1};
    stack_op_in = ccsr_pkg::STK_PUSH;
    pc_step_in = 1'b1;
    tick();
    `CHK(acc_addr_out, 24'h000100)
    `CHK(stack_addr_out, 24'h000ffc)
    `CHK(sp_next_out, 24'h000ffc)
    `CHK(pc_out, 24'h123459)
    `CHK(fetch_addr_out, 24'h123458)
    {acc_wide_in, stack_long_in, pc_load_in, pc_value_in} = {1'b0, 1'b0, 1'b1, 24'h00abcd};
    stack_op_in = ccsr_pkg::STK_POP;
    tick();
    idle();
    `CHK(acc_addr_out, 24'h000101)
    `CHK(stack_addr_out, 24'h001000)
    `CHK(sp_next_out, 24'h001002)
    `CHK(pc_out, 24'h00abcd)
    `CHK(fetch_addr_out, 24'h00abcc)
    rst_in = 1'b1;
    tick();
    rst_in = 1'b0;
    `CHK(pc_out, 24'h123457)
    `CHK(exr_out, 8'h7f)
    `CHK(ccr_out, 8'h80)
    $display("Test addressing and reset finished");
    print_verdict();
  end
endmodule
